// file: design/sfi_pkg.sv
/*
 package for the serial flash interface state block: timing, opcodes,
 field layouts and carriers. assumes a 100 MHz core clock.
*/
package sfi_pkg;
    localparam int CLK_MHZ = 100;
    localparam int T_PU_US = 300;
    localparam int T_PD_NS = 1000;
    localparam int T_RP_NS = 200;
    localparam int T_RPH_NS = 10000;
    localparam int T_RH_NS = 50;
    // longest wait is a whole count, least times round up
    localparam logic [15:0] PU_CYC = 16'(T_PU_US * CLK_MHZ);
    localparam logic [15:0] PD_CYC = 16'((T_PD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] RP_CYC = 16'((T_RP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] RPH_CYC = 16'((T_RPH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] RH_CYC = 16'((T_RH_NS * CLK_MHZ + 999) / 1000);
    localparam int ADDR_BITS = 24;
    localparam int MODE_BITS = 8;
    localparam logic [5:0] INSTR_BITS = 6'h08;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_REG_WRITE = 8'h01;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [5:0] LAT_CYC0 = 6'h08;
    localparam logic [5:0] LAT_CYC1 = 6'h04;
    localparam logic [5:0] LAT_CYC2 = 6'h02;
    localparam logic [5:0] LAT_CYC3 = 6'h00;
    localparam logic [7:0] IDLE_FILL = 8'hFF;
    localparam logic [3:0] OE_OFF = 4'hF;
    localparam logic [3:0] OE_X1 = 4'hD;
    localparam logic [3:0] OE_X2 = 4'hC;
    localparam logic [3:0] OE_X4 = 4'h0;

    typedef struct packed {
        logic quad_enable_bit;
        logic pause_pin_select_bit;
        logic [1:0] latency_code_field;
    } cfg_s;

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic write_protected;
    } cmd_s;

    typedef struct packed {
        logic known;
        logic has_addr;
        logic has_mode;
        logic [1:0] addr_w;
        logic is_read;
        logic din;
        logic [1:0] dat_w;
        logic quad_only;
    } cmd_info_s;

    typedef enum logic [1:0] {P_OFF, P_POR, P_READY, P_WARM} pwr_e;
    typedef enum logic [2:0] {
        IF_STANDBY, IF_INSTR, IF_ADDR, IF_DUMMY, IF_OUT, IF_DIN, IF_WAIT
    } if_e;
endpackage

// file: design/flash_if_states.sv
/*
 serial flash interface states: supply and restart sequencing, instruction,
 address, latency, input and output cycles, pause, plus the read data fifo.
 assumes pins and supply flags are asynchronous and are synchronised here;
 the serial clock is sampled by clk, so it must run well below clk / 4.
*/
//
// Function
// - at low supply act powered off, ignore all
// - below cut-off discard every incoming command
// - low time then min level starts cold start
// - power-up wait silent, then standby
// - restart pulse, busy and hold time then standby
// - io3 may serve as restart input
// - chip select high keeps standby
// - falling select starts instruction cycle
// - eight instruction bits, msb first, rising edges
// - write protect only in register write instruction
// - standalone command returns to standby
// - pause freezes command, floats outputs
// - resume exactly where the pause began
// - single input uses io0, no output driven
// - dummy cycles follow the latency code
// - dummy cycles ignore and never drive lines
// - single output on io1 until select high
// - dual address on io0 and io1
// - dual data out two bits per cycle
// - quad program and quad output read address on io0
// - quad input four bits per cycle
// - quad data out four bits per cycle
// - quad enable disables pause and protect
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module rd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = cnt_q != FULL;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_ready && out_valid;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module flash_if_states
    import sfi_pkg::*;
#(
    parameter logic [15:0] PU_CYCLES = PU_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic vcc_at_low,
    input wire logic vcc_below_cut,
    input wire logic vcc_at_min,
    input wire logic restart_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_n,
    input wire cfg_s cfg,
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [7:0] rd_data,
    output var cmd_s cmd,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic dev_ready
);
    function automatic logic [15:0] sat(input logic [15:0] x);
        return (x == 16'hFFFF) ? x : x + 16'h0001;
    endfunction

    function automatic logic [3:0] lanes(input logic [1:0] w);
        return 4'h1 << w;
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] r,
                                            input logic [3:0] io,
                                            input logic [1:0] w);
        unique case (w)
            2'd1: return {r[5:0], io[1:0]};
            2'd2: return {r[3:0], io[3:0]};
            default: return {r[6:0], io[0]};
        endcase
    endfunction

    function automatic logic [5:0] latency(input logic [1:0] code);
        unique case (code)
            2'd0: return LAT_CYC0;
            2'd1: return LAT_CYC1;
            2'd2: return LAT_CYC2;
            default: return LAT_CYC3;
        endcase
    endfunction

    function automatic cmd_info_s decode(input logic [7:0] op);
        cmd_info_s r;
        r = '0;
        r.known = 1'b1;
        case (op)
            OP_FAST_READ: {r.has_addr, r.is_read} = 2'b11;
            OP_DUAL_OUT_READ: begin
                {r.has_addr, r.is_read} = 2'b11;
                r.dat_w = 2'd1;
            end
            OP_DUAL_IO_READ: begin
                {r.has_addr, r.has_mode, r.is_read} = 3'b111;
                r.addr_w = 2'd1;
                r.dat_w = 2'd1;
            end
            OP_QUAD_OUT_READ: begin
                {r.has_addr, r.is_read, r.quad_only} = 3'b111;
                r.dat_w = 2'd2;
            end
            OP_QUAD_IO_READ: begin
                {r.has_addr, r.has_mode, r.is_read} = 3'b111;
                r.quad_only = 1'b1;
                r.addr_w = 2'd2;
                r.dat_w = 2'd2;
            end
            OP_QUAD_PAGE_PROGRAM: begin
                {r.has_addr, r.din, r.quad_only} = 3'b111;
                r.dat_w = 2'd2;
            end
            OP_PAGE_PROGRAM: {r.has_addr, r.din} = 2'b11;
            OP_REG_WRITE: r.din = 1'b1;
            OP_WRITE_ENABLE, OP_WRITE_DISABLE: r.known = 1'b1;
            default: r.known = 1'b0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [9:0] s1_q, s2_q;
    logic sck3_q;
    logic low_s, cut_s, min_s, rstp_s, csn_s, sck_s;
    logic [3:0] io_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 10'h3FF;
            s2_q <= 10'h3FF;
            sck3_q <= 1'b1;
        end else begin
            s1_q <= {vcc_at_low, vcc_below_cut, vcc_at_min, restart_n, cs_n,
                     sck, io_in};
            s2_q <= s1_q;
            sck3_q <= s2_q[4];
        end
    end
    assign {low_s, cut_s, min_s, rstp_s, csn_s, sck_s, io_s} = s2_q;

    ////////////////////////////////////////////////////////////////////////
    // supply and restart sequencing
    pwr_e pwr_q, pwr_d;
    logic [15:0] tmr_q, tmr_d, rlow_q, rlow_d, busy_q, busy_d;
    logic [15:0] rhold_q, rhold_d;
    logic restart_low, ready;

    assign restart_low = !rstp_s || (cfg.pause_pin_select_bit &&
                         (!cfg.quad_enable_bit || csn_s) && !io_s[3]);
    assign ready = pwr_q == P_READY;
    assign dev_ready = ready;

    always_comb begin
        pwr_d = pwr_q;
        tmr_d = tmr_q;
        busy_d = busy_q;
        rlow_d = restart_low ? sat(rlow_q) : 16'h0000;
        rhold_d = restart_low ? 16'h0000 : sat(rhold_q);
        if (low_s) begin
            pwr_d = P_OFF;
            tmr_d = (pwr_q == P_OFF) ? sat(tmr_q) : 16'h0000;
        end else begin
            unique case (pwr_q)
                P_OFF: begin
                    if (min_s && tmr_q >= PD_CYC) begin
                        pwr_d = P_POR;
                        tmr_d = 16'h0000;
                    end
                end
                P_POR: begin
                    tmr_d = sat(tmr_q);
                    if (tmr_q >= PU_CYCLES - 16'h0001) begin
                        pwr_d = P_READY;
                    end
                end
                P_READY: begin
                    if (rlow_q >= RP_CYC) begin
                        pwr_d = P_WARM;
                        busy_d = 16'h0000;
                    end
                end
                P_WARM: begin
                    busy_d = sat(busy_q);
                    if (busy_q >= RPH_CYC && rhold_q >= RH_CYC) begin
                        pwr_d = P_READY;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= P_OFF;
            tmr_q <= 16'h0000;
            rlow_q <= 16'h0000;
            busy_q <= 16'h0000;
            rhold_q <= 16'h0000;
        end else begin
            pwr_q <= pwr_d;
            tmr_q <= tmr_d;
            rlow_q <= rlow_d;
            busy_q <= busy_d;
            rhold_q <= rhold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interface state machine
    if_e if_q, if_d;
    cmd_info_s info_q, info_d, dec;
    logic [1:0] w_q, w_d;
    logic [5:0] cnt_q, cnt_d, lat;
    logic [7:0] rx_q, rx_d, tx_q, tx_d, rxb_q, rxb_d, fifo_data;
    logic [2:0] bc_q, bc_d;
    logic [3:0] txb_q, txb_d, nb, bsum, out_q, out_d, oe_q, oe_d;
    logic drv_q, drv_d, rxv_q, rxv_d, pause, rise, fall, pop, fifo_valid;
    cmd_s cmd_q, cmd_d;

    assign pause = !cfg.quad_enable_bit && !cfg.pause_pin_select_bit &&
                   !io_s[3] && !csn_s;
    assign rise = sck_s && !sck3_q && ready && !pause;
    assign fall = !sck_s && sck3_q && ready && !pause;
    assign nb = lanes(w_q);
    assign bsum = {1'b0, bc_q} + nb;
    assign lat = latency(cfg.latency_code_field);
    assign dec = decode({rx_q[6:0], io_s[0]});

    always_comb begin
        if_d = if_q;
        info_d = info_q;
        w_d = w_q;
        cnt_d = cnt_q;
        rx_d = rx_q;
        bc_d = bc_q;
        tx_d = tx_q;
        txb_d = txb_q;
        drv_d = drv_q;
        rxb_d = rxb_q;
        rxv_d = 1'b0;
        cmd_d = cmd_q;
        cmd_d.valid = 1'b0;
        pop = 1'b0;
        if (!ready || csn_s) begin
            if_d = IF_STANDBY;
            w_d = 2'd0;
            bc_d = 3'd0;
            txb_d = 4'd0;
            drv_d = 1'b0;
        end else begin
            unique case (if_q)
                IF_STANDBY: begin
                    if (!pause) begin
                        if_d = IF_INSTR;
                        cnt_d = INSTR_BITS;
                    end
                end
                IF_INSTR: begin
                    if (rise) begin
                        rx_d = {rx_q[6:0], io_s[0]};
                        cnt_d = cnt_q - 6'd1;
                        if (cnt_q == 6'd1) begin
                            info_d = dec;
                            cmd_d.valid = dec.known && !cut_s &&
                                !(dec.quad_only && !cfg.quad_enable_bit);
                            cmd_d.opcode = rx_d;
                            cmd_d.write_protected = (rx_d == OP_REG_WRITE) &&
                                !cfg.quad_enable_bit && !io_s[2];
                            if (!cmd_d.valid) begin
                                if_d = IF_WAIT;
                            end else if (dec.has_addr) begin
                                if_d = IF_ADDR;
                                w_d = dec.addr_w;
                                cnt_d = 6'((ADDR_BITS + (dec.has_mode ?
                                    MODE_BITS : 0)) >> dec.addr_w);
                            end else if (dec.din) begin
                                if_d = IF_DIN;
                                w_d = dec.dat_w;
                            end else begin
                                if_d = IF_WAIT;
                            end
                        end
                    end
                end
                IF_ADDR, IF_DIN: begin
                    if (rise) begin
                        rx_d = shift_in(rx_q, io_s, w_q);
                        bc_d = bsum[2:0];
                        if (bsum[3]) begin
                            rxv_d = 1'b1;
                            rxb_d = rx_d;
                        end
                        if (if_q == IF_ADDR) begin
                            cnt_d = cnt_q - 6'd1;
                        end
                        if (if_q == IF_ADDR && cnt_q == 6'd1) begin
                            w_d = info_q.dat_w;
                            if (info_q.din) begin
                                if_d = IF_DIN;
                            end else if (lat != 6'd0) begin
                                if_d = IF_DUMMY;
                                cnt_d = lat;
                            end else begin
                                if_d = IF_OUT;
                            end
                        end
                    end
                end
                IF_DUMMY: begin
                    // lines free by the last edge
                    if (rise) begin
                        cnt_d = cnt_q - 6'd1;
                        if (cnt_q == 6'd1) begin
                            if_d = IF_OUT;
                        end
                    end
                end
                IF_OUT: begin
                    if (fall) begin
                        drv_d = 1'b1;
                        if (txb_q == 4'd0) begin
                            pop = fifo_valid;
                            tx_d = fifo_valid ? fifo_data : IDLE_FILL;
                            txb_d = 4'd8 - nb;
                        end else begin
                            tx_d = tx_q << nb;
                            txb_d = txb_q - nb;
                        end
                    end
                end
                IF_WAIT: if_d = IF_WAIT;
            endcase
        end
        unique case (w_d)
            2'd1: out_d = {2'b00, tx_d[7:6]};
            2'd2: out_d = tx_d[7:4];
            default: out_d = {2'b00, tx_d[7], 1'b0};
        endcase
        oe_d = OE_OFF;
        if (if_d == IF_OUT && drv_d && ready && !pause && !csn_s) begin
            oe_d = (w_d == 2'd2) ? OE_X4 : (w_d == 2'd1) ? OE_X2 : OE_X1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            if_q <= IF_STANDBY;
            info_q <= '0;
            w_q <= 2'd0;
            cnt_q <= 6'd0;
            rx_q <= 8'h00;
            bc_q <= 3'd0;
            tx_q <= 8'h00;
            txb_q <= 4'd0;
            drv_q <= 1'b0;
            rxb_q <= 8'h00;
            rxv_q <= 1'b0;
            cmd_q <= '0;
            out_q <= 4'h0;
            oe_q <= OE_OFF;
        end else begin
            if_q <= if_d;
            info_q <= info_d;
            w_q <= w_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            bc_q <= bc_d;
            tx_q <= tx_d;
            txb_q <= txb_d;
            drv_q <= drv_d;
            rxb_q <= rxb_d;
            rxv_q <= rxv_d;
            cmd_q <= cmd_d;
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign io_out = out_q;
    assign io_oe_n = oe_q;
    assign cmd = cmd_q;
    assign rx_valid = rxv_q;
    assign rx_byte = rxb_q;

    rd_fifo #(.WIDTH(8), .DEPTH(32)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(rd_valid),
        .in_ready(rd_ready),
        .in_data(rd_data),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    chk_off_float:
    assert property (@(posedge clk) disable iff (!rst_n)
        (pwr_q != P_READY) && ($past(pwr_q) != P_READY) |-> io_oe_n == OE_OFF)
        else $error("lines driven while not ready");
    chk_cut_discard:
    assert property (@(posedge clk) disable iff (!rst_n)
        cmd_q.valid |-> !$past(cut_s) && $past(pwr_q) == P_READY)
        else $error("command accepted at low supply");
    chk_por_wait:
    assert property (@(posedge clk) disable iff (!rst_n)
        $past(pwr_q) == P_POR && pwr_q == P_READY |->
        $past(tmr_q) >= PU_CYCLES - 16'h0001)
        else $error("power-up wait cut short");
    chk_warm_exit:
    assert property (@(posedge clk) disable iff (!rst_n)
        $past(pwr_q) == P_WARM && pwr_q == P_READY && !$past(low_s) |->
        $past(busy_q) >= RPH_CYC && $past(rhold_q) >= RH_CYC)
        else $error("restart ended early");
    chk_cs_standby:
    assert property (@(posedge clk) disable iff (!rst_n)
        csn_s |=> if_q == IF_STANDBY ##1 (csn_s or if_q != IF_OUT))
        else $error("not in standby while deselected");
    chk_select_instr:
    assert property (@(posedge clk) disable iff (!rst_n)
        if_q == IF_STANDBY && !csn_s && ready && !pause |=> if_q == IF_INSTR)
        else $error("select did not start instruction");
    chk_pause_hold:
    assert property (@(posedge clk) disable iff (!rst_n)
        pause && ready |=> $stable(if_q) && $stable(cnt_q) && $stable(tx_q))
        else $error("state moved during pause");
    chk_pause_float:
    assert property (@(posedge clk) disable iff (!rst_n)
        pause [*2] |-> io_oe_n == OE_OFF)
        else $error("lines driven during pause");
    chk_dummy_float:
    assert property (@(posedge clk) disable iff (!rst_n)
        if_q == IF_DUMMY && $past(if_q) == IF_DUMMY |-> io_oe_n == OE_OFF)
        else $error("lines driven in latency");
    chk_addr_float:
    assert property (@(posedge clk) disable iff (!rst_n)
        if_q == IF_ADDR |-> io_oe_n[1] && io_oe_n[0])
        else $error("output driven during address");
    chk_fall_update:
    assert property (@(posedge clk) disable iff (!rst_n)
        if_q == IF_OUT && !$past(fall) && $past(if_q) == IF_OUT |->
        $stable(tx_q))
        else $error("output changed without falling edge");
endmodule

`default_nettype wire

// file: verif/spi_host.sv
/*
 host serial controller model that drives the flash pins.
 assumes clk is the core clock; serial period is 8 clk (80 ns).
*/
`timescale 1ns/10ps
`default_nettype none

module spi_host (
    input wire logic clk,
    input wire logic [3:0] dout,
    output logic cs_n,
    output logic sck,
    output logic [3:0] io
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        io = 4'hC;
    end

    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    task automatic shift(input logic [7:0] tx, input logic drv,
        output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            io[0] = drv ? tx[i] : ~io[0];
            io[1] = ~io[1];
            cs_n = 1'b0;
            half();
            sck = 1'b1;
            half();
            rx[i] = dout[1];
            sck = 1'b0;
        end
    endtask

    task automatic stop();
        half();
        cs_n = 1'b1;
        half();
    endtask
endmodule

`default_nettype wire

// file: verif/flash_if_states_test.sv
/*
 testbench: power-up, commands, fifo fill and a drained fast read.
 assumes spi_host drives the pins; short power-up wait of 50 cycles.
*/
`timescale 1ns/10ps
`default_nettype none

module flash_if_states_test;
    import sfi_pkg::*;
    logic clk, rst_n, vcc_at_low, vcc_at_min, rd_valid, rd_ready;
    logic vcc_below_cut, restart_n;
    logic cs_n, sck, rx_valid, dev_ready;
    logic [3:0] h_io, io_out, io_oe_n, pin;
    logic [7:0] rd_data, rx_byte, b;
    cfg_s cfg;
    cmd_s cmd;
    int fails, n_tests, n, n_cmd, n_rx;

    assign pin = (~io_oe_n & io_out) | (io_oe_n & h_io);
    always #5 clk = ~clk;

    // command and byte pulses seen
    always @(negedge clk) begin
        if (cmd.valid) n_cmd++;
        if (rx_valid) n_rx++;
    end

    spi_host spi_host_inst (.clk(clk), .dout(pin), .cs_n(cs_n),
        .sck(sck), .io(h_io));
    flash_if_states #(.PU_CYCLES(16'h0032)) flash_if_states_inst (
        .clk(clk), .rst_n(rst_n), .vcc_at_low(vcc_at_low),
        .vcc_below_cut(vcc_below_cut), .vcc_at_min(vcc_at_min),
        .restart_n(restart_n), .cs_n(cs_n), .sck(sck), .io_in(pin),
        .io_out(io_out), .io_oe_n(io_oe_n), .cfg(cfg),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .cmd(cmd), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .dev_ready(dev_ready));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic t_power();
        repeat (110) @(negedge clk);
        check(dev_ready, 1'b0);
        vcc_at_low = 1'b0;
        vcc_at_min = 1'b1;
        for (n = 0; n < 300 && dev_ready !== 1'b1; n++) @(negedge clk);
        if (n == 300) begin
            fails++;
            complete_run();
        end
        check(n >= 50 && n < 60, 1'b1);
        repeat (4) @(negedge clk);
        $display("test power done");
    endtask

    task automatic t_restart();
        for (int k = 0; k < 2; k++) begin
            // second pass uses io3 as restart
            cfg.pause_pin_select_bit = k[0];
            restart_n = k[0];
            spi_host_inst.io[3] = !k[0];
            repeat (30) @(negedge clk);
            check(dev_ready, 1'b0);
            restart_n = 1'b1;
            spi_host_inst.io[3] = 1'b1;
            for (n = 0; n < 1200 && dev_ready !== 1'b1; n++) @(negedge clk);
            if (n == 1200) begin
                fails++;
                complete_run();
            end
            check(n + 30 >= RPH_CYC && n < RPH_CYC, 1'b1);
        end
        cfg.pause_pin_select_bit = 1'b0;
        $display("test restart done");
    endtask

    task automatic t_cmds();
        spi_host_inst.shift(OP_WRITE_ENABLE, 1'b1, b);
        spi_host_inst.stop();
        check(cmd.opcode, OP_WRITE_ENABLE);
        check(8'(n_cmd), 8'h01);
        vcc_below_cut = 1'b1;
        spi_host_inst.shift(OP_WRITE_ENABLE, 1'b1, b);
        spi_host_inst.stop();
        vcc_below_cut = 1'b0;
        check(8'(n_cmd), 8'h01);
        spi_host_inst.shift(OP_QUAD_OUT_READ, 1'b1, b);
        spi_host_inst.stop();
        check(8'(n_cmd), 8'h01);
        cfg.quad_enable_bit = 1'b1;
        spi_host_inst.shift(OP_QUAD_OUT_READ, 1'b1, b);
        spi_host_inst.stop();
        check(cmd.opcode, OP_QUAD_OUT_READ);
        check(8'(n_cmd), 8'h02);
        cfg.quad_enable_bit = 1'b0;
        spi_host_inst.io[2] = 1'b0;
        spi_host_inst.shift(OP_REG_WRITE, 1'b1, b);
        spi_host_inst.stop();
        spi_host_inst.io[2] = 1'b1;
        check(cmd.write_protected, 1'b1);
        $display("test commands done");
    endtask

    task automatic t_read();
        rd_valid = 1'b1;
        for (n = 0; n < 40; n++) begin
            rd_data = 8'(n);
            if (rd_ready !== 1'b1) break;
            @(negedge clk);
        end
        rd_valid = 1'b0;
        check(8'(n), 8'h20);
        spi_host_inst.shift(OP_FAST_READ, 1'b1, b);
        spi_host_inst.shift(8'h12, 1'b1, b);
        spi_host_inst.shift(8'h34, 1'b1, b);
        spi_host_inst.shift(8'hA5, 1'b1, b);
        check(rx_byte, 8'hA5);
        check(8'(n_rx), 8'h03);
        check(io_oe_n, OE_OFF);
        spi_host_inst.shift(8'h00, 1'b0, b);
        check(io_oe_n, OE_OFF);
        for (int i = 0; i < 32; i++) begin
            spi_host_inst.shift(8'h00, 1'b0, b);
            check(b, 8'(i));
            check(io_oe_n, OE_X1);
            if (i == 4) begin
                // pause after the load fall is seen
                repeat (4) @(negedge clk);
                spi_host_inst.io[3] = 1'b0;
                repeat (8) @(negedge clk);
                check(io_oe_n, OE_OFF);
                spi_host_inst.io[3] = 1'b1;
            end
        end
        spi_host_inst.shift(8'h00, 1'b0, b);
        check(b, IDLE_FILL);
        spi_host_inst.stop();
        check(io_oe_n, OE_OFF);
        $display("test read done");
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        vcc_at_low = 1'b1;
        vcc_at_min = 1'b0;
        cfg = '{1'b0, 1'b0, 2'h0};
        vcc_below_cut = 1'b0;
        restart_n = 1'b1;
        rd_valid = 1'b0;
        rd_data = 8'h00;
        fails = 0;
        n_tests = 0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        t_power();
        t_restart();
        t_cmds();
        t_read();
        complete_run();
    end
endmodule

`default_nettype wire
